// [src/led_fault_sequencer.v]
/*
 * operating-state sequencer and led fault supervisor with ahb-lite registers.
 * assumes analog comparators arrive as async pins; one clk domain, sync reset.
 */
// The implementer's own choices: the AHB-Lite register port and the register offsets.
// Operation
// - current_set_pin short: flag, interrupt, force code 3FF
// - thermal: flag, interrupt, standby until clear
// - low headroom at max boost: open, disable
// - headroom high 5 ms: short, disable
// - unused output not grounded: invalid flag
// - no stop within 500 ms: serial flag
// - enable low: outputs off, discharge 400 ms
// - init: regulator, load, detect resistors
// - configuration writable from standby onward
// - standby goes straight to soft start
// - soft start 25 ms, enable supply faults
// - boost ramp 50 ms, boost faults on
// - normal: drivers on while brightness nonzero
// - recovery 100 ms, restart if brightness nonzero
// - all strings off: latch until enable low
// - serial timeout resets serial block, interrupt
`timescale 1ns/1ps
`include "led_seq_defines.vh"
module led_fault_sequencer #(
	parameter N = 4,
	parameter integer SOFTSTART_CYC = `MS_TO_CYC(`T_SOFTSTART_MS),
	parameter integer BOOSTRAMP_CYC = `MS_TO_CYC(`T_BOOSTRAMP_MS),
	parameter integer RECOVERY_CYC = `MS_TO_CYC(`T_RECOVERY_MS),
	parameter integer DISCHARGE_CYC = `MS_TO_CYC(`T_DISCHARGE_MS),
	parameter integer SERIAL_TO_CYC = `MS_TO_CYC(`T_SERIAL_TO_MS),
	parameter integer SHORT_QUAL_CYC = `MS_TO_CYC(`T_SHORT_QUAL_MS)
) (
	input wire clk,
	input wire srst,
	input wire hsel,
	input wire [31:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire [2:0] hsize,
	input wire [31:0] hwdata,
	input wire hready,
	output reg [31:0] hrdata,
	output reg hreadyout,
	output reg hresp,
	input wire enable_pin,
	input wire init_done,
	input wire current_set_pin,
	input wire thermal_hot,
	input wire boost_at_max,
	input wire serial_busy,
	input wire serial_stop,
	input wire [N-1:0] headroom_low,
	input wire [N-1:0] headroom_high,
	input wire [N-1:0] ground_short_level,
	input wire [N-1:0] string_used,
	output reg int_out,
	output reg boost_en,
	output reg pl_switch_en,
	output reg boost_discharge,
	output reg ldo_en,
	output reg config_load,
	output reg serial_reset,
	output reg cfg_write_ok,
	output reg test_current_en,
	output reg boost_limit_low,
	output reg [N-1:0] string_drive_en,
	output reg [11:0] sink_drive_dac_code
);
	localparam S_OFF = 3'd0;
	localparam S_INIT = 3'd1;
	localparam S_STANDBY = 3'd2;
	localparam S_SOFT = 3'd3;
	localparam S_RAMP = 3'd4;
	localparam S_NORMAL = 3'd5;
	localparam S_RECOVER = 3'd6;
	localparam S_LATCH = 3'd7;
	localparam [31:0] ONE = 32'h00000001;

	wire en_s;
	wire current_set_pin_s;
	wire hot_s;
	wire bmax_s;
	wire [N-1:0] hl_s;
	wire [N-1:0] hh_s;
	wire [N-1:0] gnd_s;

	pin_sync3 #(.W(4 + 3 * N)) u_sync (
		.clk(clk),
		.srst(srst),
		.d({enable_pin, current_set_pin, thermal_hot, boost_at_max,
			headroom_low, headroom_high, ground_short_level}),
		.q({en_s, current_set_pin_s, hot_s, bmax_s, hl_s, hh_s, gnd_s})
	);

	reg [2:0] state_reg;
	reg [2:0] state_next;
	reg [31:0] tmr_reg;
	reg [31:0] ser_tmr_reg;
	reg [31:0] short_tmr_reg [0:N-1];
	reg [`ST_WIDTH-1:0] status_reg;
	reg [`ST_WIDTH-1:0] set_now;
	reg [N-1:0] dead_reg;
	reg [N-1:0] open_hit;
	reg [N-1:0] short_hit;
	reg [15:0] brt_reg;
	reg [11:0] dac_cfg_reg;
	reg ph_valid_reg;
	reg ph_write_reg;
	reg [7:0] ph_addr_reg;
	reg gnd_fault;
	wire timer_done;

	assign timer_done = (state_reg == S_SOFT && tmr_reg >= SOFTSTART_CYC - 1)
		|| (state_reg == S_RAMP && tmr_reg >= BOOSTRAMP_CYC - 1)
		|| (state_reg == S_RECOVER && tmr_reg >= RECOVERY_CYC - 1)
		|| (state_reg == S_OFF && tmr_reg >= DISCHARGE_CYC - 1);

	// per-channel string fault detection, plus current-set, thermal and serial status set terms
	integer k;
	always @*
	begin
		open_hit = {N{1'b0}};
		short_hit = {N{1'b0}};
		gnd_fault = 1'b0;
		set_now = {`ST_WIDTH{1'b0}};
		for (k = 0; k < N; k = k + 1)
		begin
			if (state_reg == S_NORMAL && string_used[k] && !dead_reg[k] && hl_s[k] && bmax_s)
				open_hit[k] = 1'b1;
			if (state_reg == S_NORMAL && string_used[k] && !dead_reg[k]
				&& short_tmr_reg[k] >= SHORT_QUAL_CYC)
				short_hit[k] = 1'b1;
			if (string_used[k] && gnd_s[k] && (state_reg == S_SOFT
				|| ((state_reg == S_RAMP || state_reg == S_NORMAL) && !string_drive_en[k])))
				gnd_fault = 1'b1;
			if (state_reg == S_SOFT && !string_used[k] && !gnd_s[k])
				set_now[`ST_INVALID] = 1'b1;
		end
		set_now[`ST_CUR_SET] = current_set_pin_s && state_reg != S_OFF;
		set_now[`ST_THERMAL] = hot_s && state_reg >= S_SOFT && state_reg <= S_NORMAL;
		set_now[`ST_OPEN] = |open_hit;
		set_now[`ST_INT_SHORT] = |short_hit;
		set_now[`ST_GND_SHORT] = gnd_fault;
		set_now[`ST_SERIAL] = ser_tmr_reg >= SERIAL_TO_CYC - 1;
	end

	always @*
	begin
		state_next = state_reg;
		case (state_reg)
			S_OFF:
				if (en_s && tmr_reg >= DISCHARGE_CYC - 1)
					state_next = S_INIT;
			S_INIT:
				if (init_done)
					state_next = S_STANDBY;
			S_STANDBY:
				if (!hot_s)
					state_next = S_SOFT;
			S_SOFT:
				if (timer_done)
					state_next = S_RAMP;
			S_RAMP:
				if (timer_done)
					state_next = S_NORMAL;
			S_RECOVER:
				if (timer_done && brt_reg != 16'h0000)
					state_next = S_STANDBY;
			S_LATCH:
				state_next = S_LATCH;
			default:
				state_next = state_reg;
		endcase
		if (state_reg >= S_SOFT && state_reg <= S_NORMAL)
		begin
			if (gnd_fault)
				state_next = S_RECOVER;
			if (hot_s)
				state_next = S_STANDBY;
		end
		if (state_reg == S_NORMAL && (&((dead_reg | open_hit | short_hit) | ~string_used))
			&& (|string_used))
			state_next = S_LATCH;
		if (!en_s && state_reg != S_OFF)
			state_next = S_OFF;
	end

	genvar g;
	generate
		for (g = 0; g < N; g = g + 1)
		begin : g_short
			always @(posedge clk)
			begin
				if (srst || !(hh_s[g] && |(~hh_s & string_used & ~dead_reg)) || dead_reg[g])
					short_tmr_reg[g] <= 32'h00000000;
				else if (short_tmr_reg[g] < SHORT_QUAL_CYC)
					short_tmr_reg[g] <= short_tmr_reg[g] + ONE;
			end
		end
	endgenerate

	always @(posedge clk)
	begin
		if (srst)
		begin
			state_reg <= S_OFF;
			tmr_reg <= 32'h00000000;
			ser_tmr_reg <= 32'h00000000;
			status_reg <= {`ST_WIDTH{1'b0}};
			dead_reg <= {N{1'b0}};
			brt_reg <= 16'h0000;
			dac_cfg_reg <= `DAC_RESET_CODE;
			ph_valid_reg <= 1'b0;
			ph_write_reg <= 1'b0;
			ph_addr_reg <= 8'h00;
			hrdata <= 32'h00000000;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			int_out <= 1'b0;
			serial_reset <= 1'b0;
		end
		else
		begin
			state_reg <= state_next;
			if (state_next != state_reg)
				tmr_reg <= 32'h00000000;
			else
				tmr_reg <= tmr_reg + ONE;
			serial_reset <= set_now[`ST_SERIAL];
			if (!serial_busy || serial_stop || set_now[`ST_SERIAL])
				ser_tmr_reg <= 32'h00000000;
			else
				ser_tmr_reg <= ser_tmr_reg + ONE;
			if (state_reg == S_OFF)
				dead_reg <= {N{1'b0}};
			else
				dead_reg <= dead_reg | open_hit | short_hit;
			ph_valid_reg <= hsel && hready && htrans[1];
			ph_write_reg <= hwrite;
			ph_addr_reg <= haddr[7:0];
			hrdata <= 32'h00000000;
			if (hsel && hready && htrans[1] && !hwrite)
			begin
				case (haddr[7:0])
					`OFS_CTRL: hrdata <= {16'h0000, brt_reg};
					`OFS_STATUS: hrdata <= {{(32-`ST_WIDTH){1'b0}}, status_reg};
					`OFS_STRING: hrdata <= {{(32-N){1'b0}}, dead_reg};
					`OFS_STATE: hrdata <= {29'h00000000, state_reg};
					`OFS_DAC: hrdata <= {20'h00000, sink_drive_dac_code};
					default: hrdata <= 32'h00000000;
				endcase
			end
			if (ph_valid_reg && ph_write_reg && state_reg >= S_STANDBY)
			begin
				if (ph_addr_reg == `OFS_CTRL)
					brt_reg <= hwdata[`CTRL_BRT_LSB +: `CTRL_BRT_W];
				if (ph_addr_reg == `OFS_DAC)
					dac_cfg_reg <= hwdata[11:0];
			end
			// set wins over write-one clear
			if (ph_valid_reg && ph_write_reg && ph_addr_reg == `OFS_STATUS)
				status_reg <= (status_reg & ~hwdata[`ST_WIDTH-1:0]) | set_now;
			else
				status_reg <= status_reg | set_now;
			int_out <= |(status_reg | set_now);
		end
	end

	// output decode, registered
	always @(posedge clk)
	begin
		if (srst)
		begin
			boost_en <= 1'b0;
			pl_switch_en <= 1'b0;
			boost_discharge <= 1'b0;
			ldo_en <= 1'b0;
			config_load <= 1'b0;
			cfg_write_ok <= 1'b0;
			test_current_en <= 1'b0;
			boost_limit_low <= 1'b0;
			string_drive_en <= {N{1'b0}};
			sink_drive_dac_code <= `DAC_RESET_CODE;
		end
		else
		begin
			boost_discharge <= state_next == S_OFF && !(state_reg == S_OFF && timer_done);
			ldo_en <= state_next != S_OFF;
			config_load <= state_next == S_INIT;
			cfg_write_ok <= state_next >= S_STANDBY;
			pl_switch_en <= state_next >= S_SOFT && state_next <= S_NORMAL;
			boost_en <= state_next == S_RAMP || state_next == S_NORMAL;
			boost_limit_low <= state_next == S_RAMP;
			test_current_en <= state_next >= S_SOFT && state_next <= S_NORMAL;
			if (state_next == S_NORMAL && brt_reg != 16'h0000)
				string_drive_en <= string_used & ~(dead_reg | open_hit | short_hit);
			else
				string_drive_en <= {N{1'b0}};
			sink_drive_dac_code <= current_set_pin_s ? `CURRENT_SET_PIN_FORCE_CODE : dac_cfg_reg;
		end
	end
endmodule // led_fault_sequencer

// [src/led_seq_defines.vh]
/*
 * timing constants, field positions and reset values for the led fault sequencer.
 * assumes a 100 MHz clock; included by bare name.
 */
`ifndef LED_SEQ_DEFINES_VH
`define LED_SEQ_DEFINES_VH

`define CLK_MHZ 100
`define T_SOFTSTART_MS 25
`define T_BOOSTRAMP_MS 50
`define T_RECOVERY_MS 100
`define T_DISCHARGE_MS 400
`define T_SERIAL_TO_MS 500
`define T_SHORT_QUAL_MS 5
`define MS_TO_CYC(ms) ((ms) * 1000 * `CLK_MHZ)

`define CURRENT_SET_PIN_FORCE_CODE 12'h3FF
`define DAC_RESET_CODE 12'hFFF

`define OFS_CTRL 8'h00
`define OFS_STATUS 8'h04
`define OFS_STRING 8'h08
`define OFS_STATE 8'h0C
`define OFS_DAC 8'h10

`define ST_CUR_SET 0
`define ST_THERMAL 1
`define ST_OPEN 2
`define ST_INT_SHORT 3
`define ST_GND_SHORT 4
`define ST_INVALID 5
`define ST_SERIAL 6
`define ST_WIDTH 7

`define CTRL_BRT_LSB 0
`define CTRL_BRT_W 16
`define CTRL_CLEAR_BIT 31

`endif

// [src/pin_sync3.v]
/*
 * three-stage synchroniser for a vector of pins, with agreement filter.
 * assumes inputs asynchronous to clk.
 */
`timescale 1ns/1ps
module pin_sync3 #(
	parameter W = 1
) (
	input wire clk,
	input wire srst,
	input wire [W-1:0] d,
	output reg [W-1:0] q
);
	reg [W-1:0] s1_reg;
	reg [W-1:0] s2_reg;
	reg [W-1:0] s3_reg;
	integer i;

	always @(posedge clk)
	begin
		if (srst)
		begin
			s1_reg <= {W{1'b0}};
			s2_reg <= {W{1'b0}};
			s3_reg <= {W{1'b0}};
			q <= {W{1'b0}};
		end
		else
		begin
			s1_reg <= d;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			// change counts once stages two and three agree
			for (i = 0; i < W; i = i + 1)
				if (s2_reg[i] == s3_reg[i])
					q[i] <= s3_reg[i];
		end
	end
endmodule // pin_sync3

// [testbench/led_seq_assertions.sv]
/*
 * checker: timing relations between the sequencer's fault inputs and its outputs.
 * assumes timer parameters of at least 8 cycles; bound into every sequencer.
 */
`timescale 1ns/1ps
module led_seq_assertions #(
	parameter N = 4
) (
	input wire clk,
	input wire srst,
	input wire enable_pin,
	input wire current_set_pin,
	input wire thermal_hot,
	input wire serial_reset,
	input wire int_out,
	input wire boost_en,
	input wire pl_switch_en,
	input wire boost_discharge,
	input wire [N-1:0] string_drive_en,
	input wire [11:0] sink_drive_dac_code
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (srst);
	property p_cur_int;
		current_set_pin [*6] |-> ##[0:4] int_out;
	endproperty
	a_cur_int: assert property (p_cur_int) else $error("no interrupt on current-set");
	property p_cur_code;
		current_set_pin [*6] |-> ##[0:4] sink_drive_dac_code == 12'h3FF;
	endproperty
	a_cur_code: assert property (p_cur_code) else $error("code not forced");
	property p_hot;
		thermal_hot [*6] |-> ##[0:4] (int_out && !boost_en);
	endproperty
	a_hot: assert property (p_hot) else $error("hot but running");
	property p_off;
		!enable_pin [*6] |-> ##[0:3] (!boost_en && !pl_switch_en && string_drive_en == 0);
	endproperty
	a_off: assert property (p_off) else $error("outputs on with enable low");
	property p_dis;
		$rose(boost_discharge) |-> boost_discharge [*8];
	endproperty
	a_dis: assert property (p_dis) else $error("discharge too short");
	property p_soft;
		$rose(pl_switch_en) |-> !boost_en [*8];
	endproperty
	a_soft: assert property (p_soft) else $error("boost during soft start");
	property p_drv;
		|string_drive_en |-> (boost_en && pl_switch_en);
	endproperty
	a_drv: assert property (p_drv) else $error("strings driven without boost");
	property p_rec;
		$fell(pl_switch_en) |=> !pl_switch_en [*8];
	endproperty
	a_rec: assert property (p_rec) else $error("restart too early");
	property p_ser;
		$rose(serial_reset) |-> ##[0:2] int_out;
	endproperty
	a_ser: assert property (p_ser) else $error("no interrupt on serial reset");
	c_norm: cover property (|string_drive_en);
	c_dis: cover property ($rose(boost_discharge));
	c_ser: cover property ($rose(serial_reset));
endmodule // led_seq_assertions

bind led_fault_sequencer led_seq_assertions #(.N(N)) u_chk (.clk, .srst, .enable_pin,
	.current_set_pin, .thermal_hot, .serial_reset, .int_out, .boost_en, .pl_switch_en,
	.boost_discharge, .string_drive_en, .sink_drive_dac_code);

// [testbench/host_model.sv]
/*
 * host model: drives the enable pin and frames serial commands.
 * assumes requests from the testbench arrive just after rising edges.
 */
`timescale 1ns/1ps
module host_model (
	input wire clk,
	input wire en_req,
	input wire cmd_req,
	input wire cmd_end,
	output reg enable_pin,
	output reg serial_busy,
	output reg serial_stop
);
	initial
	begin
		enable_pin = 1'b0;
		serial_busy = 1'b0;
		serial_stop = 1'b0;
	end
	always @(posedge clk)
	begin
		enable_pin <= en_req;
		serial_stop <= serial_busy & cmd_end;
		if (cmd_req)
			serial_busy <= 1'b1;
		else if (cmd_end)
			serial_busy <= 1'b0;
	end
endmodule // host_model

// [testbench/test_led_driver_state_fault_sequencer.sv]
/*
 * testbench: walks the sequencer through start-up, faults and shutdown over ahb-lite.
 * assumes the checker and host model are compiled first.
 */
`timescale 1ns/1ps
module test_led_driver_state_fault_sequencer;
	localparam SS = 20;
	localparam TO = 50;
	localparam SQ = 20;
	reg clk, srst, en_req, cmd_req, cmd_end, init_done, csp, hot, bmax, hwrite, hsel;
	reg [1:0] htrans;
	reg [31:0] haddr, hwdata, q;
	reg [3:0] hl, hh, gsl, used;
	reg sr_seen = 1'b0, ld_seen = 1'b0;
	wire [31:0] hrdata;
	wire rdy, enable_pin, serial_busy, serial_stop, pl, boost, dis, int_out;
	wire ldo, cfl, sres, cfgok, tce, blim, hrsp;
	wire [3:0] drv;
	wire [11:0] dac;
	integer n_errors = 0, cmp_count = 0, cyc = 0, k;
	led_fault_sequencer #(.SOFTSTART_CYC(SS), .BOOSTRAMP_CYC(30), .RECOVERY_CYC(40),
		.DISCHARGE_CYC(25), .SERIAL_TO_CYC(TO), .SHORT_QUAL_CYC(SQ)) dut (
		.clk(clk), .srst(srst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(rdy), .hrdata(hrdata),
		.hreadyout(rdy), .hresp(hrsp), .enable_pin(enable_pin), .init_done(init_done),
		.current_set_pin(csp), .thermal_hot(hot), .boost_at_max(bmax),
		.serial_busy(serial_busy), .serial_stop(serial_stop), .headroom_low(hl),
		.headroom_high(hh), .ground_short_level(gsl), .string_used(used),
		.int_out(int_out), .boost_en(boost), .pl_switch_en(pl), .boost_discharge(dis),
		.ldo_en(ldo), .config_load(cfl), .serial_reset(sres), .cfg_write_ok(cfgok),
		.test_current_en(tce), .boost_limit_low(blim), .string_drive_en(drv),
		.sink_drive_dac_code(dac));
	host_model host (.clk(clk), .en_req(en_req), .cmd_req(cmd_req), .cmd_end(cmd_end),
		.enable_pin(enable_pin), .serial_busy(serial_busy), .serial_stop(serial_stop));
	task finish_test;
		begin
			$display("errors %0d compares %0d", n_errors, cmp_count);
			if (n_errors == 0 && cmp_count > 0)
				$display("Run complete: PASS");
			else
				$display("Run complete: FAIL");
			$finish;
		end
	endtask
	task chk(input [31:0] s, input [31:0] e);
		begin
			cmp_count = cmp_count + 1;
			if (s !== e)
			begin
				n_errors = n_errors + 1;
				$display("wrong value at %0t: got %h want %h", $time, s, e);
			end
		end
	endtask
	task ahb(input [31:0] a, input w, input [31:0] d);
		begin
			haddr <= a;
			hwrite <= w;
			htrans <= 2'h2;
			@(posedge clk);
			while (rdy !== 1'b1)
				@(posedge clk);
			htrans <= 2'h0;
			hwdata <= d;
			@(posedge clk);
			while (rdy !== 1'b1)
				@(posedge clk);
			q = hrdata;
		end
	endtask
	task wst(input [31:0] s);
		begin
			q = 32'hFFFF;
			while (q !== s)
				ahb(32'h0C, 1'b0, 32'h0);
		end
	endtask
	task stat(input [31:0] m);
		begin
			ahb(32'h04, 1'b0, 32'h0);
			chk(q & m, m);
			ahb(32'h04, 1'b1, 32'h7F);
		end
	endtask
	task cmd(input ok);
		begin
			cmd_req <= 1'b1;
			@(posedge clk);
			cmd_req <= 1'b0;
			repeat (ok ? 10 : TO + 10) @(posedge clk);
			cmd_end <= 1'b1;
			@(posedge clk);
			cmd_end <= 1'b0;
		end
	endtask
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		if (sres)
			sr_seen <= 1'b1;
		if (cfl)
			ld_seen <= 1'b1;
		if (cyc == 20000)
		begin
			n_errors = n_errors + 1;
			finish_test;
		end
	end
	initial
	begin
		{srst, en_req, cmd_req, cmd_end, init_done, csp, hot, bmax} = 8'h80;
		{hwrite, htrans, haddr, hwdata, hl, hh, gsl} = 0;
		{hsel, used} = 5'h17;
		repeat (12) @(posedge clk);
		srst <= 1'b0;
		ahb(32'h00, 1'b1, 32'h100);
		ahb(32'h00, 1'b0, 32'h0);
		chk(q, 32'h0);
		ahb(32'h14, 1'b0, 32'h0);
		chk(q, 32'h0);
		chk(hrsp, 1'b0);
		en_req <= 1'b1;
		init_done <= 1'b1;
		while (pl !== 1'b1)
			@(negedge clk);
		chk({ldo, cfgok, tce}, 3'h7);
		for (k = 0; boost !== 1'b1; k = k + 1)
			@(negedge clk);
		chk(k >= SS - 1 && k <= SS + 1, 1);
		chk(blim, 1'b1);
		@(posedge clk);
		wst(5);
		chk(blim, 1'b0);
		chk(ld_seen, 1'b1);
		ahb(32'h00, 1'b1, 32'h100);
		repeat (8) @(posedge clk);
		chk(drv, 4'h7);
		hsel <= 1'b0;
		ahb(32'h00, 1'b1, 32'h0);
		hsel <= 1'b1;
		repeat (4) @(posedge clk);
		chk(drv, 4'h7);
		ahb(32'h00, 1'b1, 32'h0);
		repeat (8) @(posedge clk);
		chk(drv, 4'h0);
		ahb(32'h00, 1'b1, 32'h100);
		stat(32'h20);
		cmd(1'b1);
		ahb(32'h04, 1'b0, 32'h0);
		chk(q & 32'h40, 32'h0);
		chk(sr_seen, 1'b0);
		cmd(1'b0);
		chk(int_out, 1'b1);
		chk(sr_seen, 1'b1);
		stat(32'h40);
		csp <= 1'b1;
		repeat (10) @(posedge clk);
		chk(dac, 12'h3FF);
		stat(32'h01);
		wst(5);
		csp <= 1'b0;
		hl <= 4'h1;
		bmax <= 1'b1;
		repeat (10) @(posedge clk);
		{hl, bmax} <= 0;
		stat(32'h04);
		hh <= 4'h2;
		repeat (SQ + 10) @(posedge clk);
		hh <= 4'h0;
		stat(32'h08);
		ahb(32'h08, 1'b0, 32'h0);
		chk(q & 32'hF, 32'h3);
		chk(drv, 4'h4);
		hot <= 1'b1;
		repeat (10) @(posedge clk);
		wst(2);
		stat(32'h02);
		gsl <= 4'h4;
		hot <= 1'b0;
		wst(6);
		chk(pl, 1'b0);
		stat(32'h10);
		gsl <= 4'h0;
		wst(5);
		hl <= 4'h4;
		bmax <= 1'b1;
		wst(7);
		chk(drv, 4'h0);
		en_req <= 1'b0;
		repeat (8) @(posedge clk);
		chk({dis, boost, pl}, 3'h4);
		wst(0);
		chk({ldo, cfgok}, 2'h0);
		finish_test;
	end
endmodule // test_led_driver_state_fault_sequencer
